// File: twsd_pkg.sv
/*
  Shared constants and types for the two-wire serial slave with memory
  access. Assumes a single system clock domain; all users import it whole.
*/
package twsd_pkg;
  localparam int BYTE_W = 8;
  localparam int ADDR7_W = 7;
  localparam int CNT_W = 13;
  localparam int PTR_W = 32;
  localparam int SYNC_W = 2;
  // bit counter values within one byte
  localparam logic [3:0] BIT_CNT_RST = 4'h0;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  // values after reset, and the count increment of one
  localparam logic [PTR_W-1:0] PTR_RST = 32'h00000000;
  localparam logic [CNT_W-1:0] CNT_RST = 13'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 13'h0001;
  localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
  localparam logic [SYNC_W-1:0] SYNC_RST = 2'h3;
  // zero extension of a byte count onto a memory pointer
  localparam logic [PTR_W-CNT_W-1:0] PTR_PAD = 19'h00000;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_WAIT_PREP,
    ST_TX_FETCH,
    ST_TX_BITS,
    ST_TX_ACKCHK,
    ST_RX_BITS,
    ST_RX_ACK,
    ST_RX_ACKBIT,
    ST_HOLD,
    ST_STOPPING
  } twsd_state_t;
endpackage

// File: twsd_sync2.sv
/*
  Two-stage synchroniser for the serial clock and data pins.
  Assumes the pins are asynchronous to i_sys_clk; idles high like a bus.
*/
`timescale 1ns/1ps
module twsd_sync2
  import twsd_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic i_clk_en,
  input wire logic [SYNC_W-1:0] i_async,
  output logic [SYNC_W-1:0] o_sync
);
  logic [SYNC_W-1:0] meta_q;
  logic [SYNC_W-1:0] meta_d;
  logic [SYNC_W-1:0] sync_d;

  ////////////////////////////////////////////////////////////////////////
  // first stage feeds only the second stage
  always_comb begin
    meta_d = i_async;
    sync_d = meta_q;
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      meta_q <= SYNC_RST;
      o_sync <= SYNC_RST;
    end else if (i_clk_en) begin
      meta_q <= meta_d;
      o_sync <= sync_d;
    end
  end
endmodule

// File: twsd_serial_slave_unit.sv
/*
  Two-wire serial slave with autonomous byte access to system memory.
  Assumes one bus master, pins sampled on i_sys_clk at 100 MHz, and a
  memory port answering each request with a one-cycle i_mem_ack.
*/
`timescale 1ns/1ps
module twsd_serial_slave_unit
  import twsd_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic i_clk_en,
  input wire logic i_enable,
  input wire logic [ADDR7_W-1:0] i_addr0,
  input wire logic i_addr0_en,
  input wire logic [ADDR7_W-1:0] i_addr1,
  input wire logic i_addr1_en,
  input wire logic [PTR_W-1:0] i_tx_ptr,
  input wire logic [CNT_W-1:0] i_tx_maxcnt,
  input wire logic [PTR_W-1:0] i_rx_ptr,
  input wire logic [CNT_W-1:0] i_rx_maxcnt,
  input wire logic [BYTE_W-1:0] i_over_read_fill_byte,
  input wire logic i_prepare_transmit_task,
  input wire logic i_prepare_receive_task,
  input wire logic i_stop_task,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_scl_out,
  output logic o_scl_oe,
  output logic o_sda_out,
  output logic o_sda_oe,
  output logic o_mem_req,
  output logic o_mem_we,
  output logic [PTR_W-1:0] o_mem_addr,
  output logic [BYTE_W-1:0] o_mem_wdata,
  input wire logic i_mem_ack,
  input wire logic [BYTE_W-1:0] i_mem_rdata,
  output logic o_receive_begun_event,
  output logic o_transmit_begun_event,
  output logic o_stopped_event,
  output logic o_error_event,
  output logic o_read_event,
  output logic o_write_event,
  output logic [CNT_W-1:0] o_tx_amount,
  output logic [CNT_W-1:0] o_rx_amount,
  output logic o_sleep
);
  twsd_state_t state_q, state_d;
  logic [SYNC_W-1:0] pins_s;
  logic scl_s, sda_s, scl_p_q, scl_p_d, sda_p_q, sda_p_d;
  logic [BYTE_W-1:0] shift_q, shift_d, byte_v;
  logic [3:0] bitcnt_q, bitcnt_d;
  logic rw_q, rw_d, active_q, active_d, fetch_q, fetch_d, load_v;
  logic tx_prep_q, tx_prep_d, rx_prep_q, rx_prep_d;
  logic scl_oe_d, sda_oe_d, mem_req_d, mem_we_d, sleep_d;
  logic [PTR_W-1:0] ptr_q, ptr_d, mem_addr_d;
  logic [BYTE_W-1:0] mem_wdata_d;
  logic [CNT_W-1:0] max_q, max_d, cnt_q, cnt_d, tx_amt_d, rx_amt_d;
  logic rxb_d, txb_d, stp_d, err_d, rd_d, wr_d;
  logic scl_rise, scl_fall, start_seen, stop_seen, addr_hit;

  ////////////////////////////////////////////////////////////////////////
  // pins cross into the system clock; 100 MHz oversamples 400 kHz ample
  twsd_sync2 u_sync (
    .i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n),
    .i_clk_en(i_clk_en),
    .i_async({i_scl, i_sda}),
    .o_sync(pins_s)
  );
  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  // bus edges and conditions from the synchronised copies only
  assign scl_rise = scl_s & ~scl_p_q;
  assign scl_fall = ~scl_s & scl_p_q;
  assign start_seen = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_seen = scl_s & scl_p_q & ~sda_p_q & sda_s;
  // no arbitration logic: a lone master is assumed
  assign addr_hit = (i_addr0_en && shift_q[7:1] == i_addr0) ||
                    (i_addr1_en && shift_q[7:1] == i_addr1);

  ////////////////////////////////////////////////////////////////////////
  // next-state logic for the whole slave
  always_comb begin
    state_d = state_q;
    scl_p_d = scl_s;
    sda_p_d = sda_s;
    shift_d = shift_q;
    bitcnt_d = bitcnt_q;
    rw_d = rw_q;
    active_d = active_q;
    fetch_d = fetch_q;
    tx_prep_d = tx_prep_q;
    rx_prep_d = rx_prep_q;
    scl_oe_d = o_scl_oe;
    sda_oe_d = o_sda_oe;
    ptr_d = ptr_q;
    max_d = max_q;
    cnt_d = cnt_q;
    tx_amt_d = o_tx_amount;
    rx_amt_d = o_rx_amount;
    mem_req_d = o_mem_req & ~i_mem_ack;
    mem_we_d = o_mem_we;
    mem_addr_d = o_mem_addr;
    mem_wdata_d = o_mem_wdata;
    {rxb_d, txb_d, stp_d, err_d, rd_d, wr_d} = 6'h00;
    byte_v = i_over_read_fill_byte;
    load_v = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (start_seen) begin
          state_d = ST_ADDR;
          bitcnt_d = BIT_CNT_RST;
        end
      end
      ST_ADDR: begin
        if (scl_rise) begin
          shift_d = {shift_q[6:0], sda_s};
          bitcnt_d = bitcnt_q + 4'h1;
        end else if (scl_fall && bitcnt_q == BITS_PER_BYTE) begin
          if (addr_hit) begin
            sda_oe_d = 1'b1;
            rw_d = shift_q[0];
            rd_d = shift_q[0];
            wr_d = ~shift_q[0];
            state_d = ST_ADDR_ACK;
          end else begin
            state_d = ST_HOLD;
          end
        end
      end
      ST_ADDR_ACK: begin
        // hold the clock low from the ack fall onward
        if (scl_fall) begin
          sda_oe_d = 1'b0;
          scl_oe_d = 1'b1;
          state_d = ST_WAIT_PREP;
        end
      end
      ST_WAIT_PREP: begin
        // clock stays stretched until the matching flag is set
        if (rw_q && tx_prep_q) begin
          tx_prep_d = 1'b0;
          txb_d = 1'b1;
          ptr_d = i_tx_ptr;
          max_d = i_tx_maxcnt;
          cnt_d = CNT_RST;
          fetch_d = 1'b0;
          active_d = 1'b1;
          state_d = ST_TX_FETCH;
        end else if (!rw_q && rx_prep_q) begin
          rx_prep_d = 1'b0;
          rxb_d = 1'b1;
          ptr_d = i_rx_ptr;
          max_d = i_rx_maxcnt;
          cnt_d = CNT_RST;
          active_d = 1'b1;
          scl_oe_d = 1'b0;
          bitcnt_d = BIT_CNT_RST;
          state_d = ST_RX_BITS;
        end
      end
      ST_TX_FETCH: begin
        // the clock is held low while the next byte is fetched
        if (cnt_q >= max_q) begin
          err_d = 1'b1;
          load_v = 1'b1;
        end else if (!fetch_q && !o_mem_req) begin
          mem_req_d = 1'b1;
          mem_we_d = 1'b0;
          mem_addr_d = ptr_q + {PTR_PAD, cnt_q};
          fetch_d = 1'b1;
        end else if (fetch_q && i_mem_ack) begin
          byte_v = i_mem_rdata;
          load_v = 1'b1;
        end
        if (load_v) begin
          shift_d = byte_v;
          sda_oe_d = ~byte_v[7];
          scl_oe_d = 1'b0;
          fetch_d = 1'b0;
          cnt_d = cnt_q + CNT_ONE;
          tx_amt_d = cnt_q + CNT_ONE;
          bitcnt_d = BIT_CNT_RST;
          state_d = ST_TX_BITS;
        end
      end
      ST_TX_BITS: begin
        // data changes only while the clock is low
        if (scl_fall) begin
          if (bitcnt_q == LAST_BIT) begin
            sda_oe_d = 1'b0;
            state_d = ST_TX_ACKCHK;
          end else begin
            shift_d = {shift_q[6:0], 1'b0};
            sda_oe_d = ~shift_q[6];
            bitcnt_d = bitcnt_q + 4'h1;
          end
        end
      end
      ST_TX_ACKCHK: begin
        // a nack ends sending; the master then issues stop
        if (scl_rise) begin
          shift_d[0] = sda_s;
        end else if (scl_fall) begin
          if (shift_q[0]) begin
            state_d = ST_HOLD;
          end else begin
            scl_oe_d = 1'b1;
            state_d = ST_TX_FETCH;
          end
        end
      end
      ST_RX_BITS: begin
        if (scl_rise) begin
          shift_d = {shift_q[6:0], sda_s};
          bitcnt_d = bitcnt_q + 4'h1;
        end else if (scl_fall && bitcnt_q == BITS_PER_BYTE) begin
          scl_oe_d = 1'b1;
          state_d = ST_RX_ACK;
        end
      end
      ST_RX_ACK: begin
        // stretch until the previous write has drained
        if (!o_mem_req) begin
          if (cnt_q < max_q) begin
            sda_oe_d = 1'b1;
            mem_req_d = 1'b1;
            mem_we_d = 1'b1;
            mem_addr_d = ptr_q + {PTR_PAD, cnt_q};
            mem_wdata_d = shift_q;
            cnt_d = cnt_q + CNT_ONE;
            rx_amt_d = cnt_q + CNT_ONE;
          end else begin
            err_d = 1'b1;
          end
          scl_oe_d = 1'b0;
          state_d = ST_RX_ACKBIT;
        end
      end
      ST_RX_ACKBIT: begin
        if (scl_fall) begin
          sda_oe_d = 1'b0;
          bitcnt_d = BIT_CNT_RST;
          state_d = ST_RX_BITS;
        end
      end
      ST_STOPPING: begin
        // buffer is only handed back once memory traffic is over
        scl_oe_d = 1'b0;
        sda_oe_d = 1'b0;
        if (!o_mem_req) begin
          stp_d = 1'b1;
          active_d = 1'b0;
          if (rw_q) begin
            tx_prep_d = 1'b0;
          end else begin
            rx_prep_d = 1'b0;
          end
          state_d = ST_IDLE;
        end
      end
      default: begin
      end
    endcase
    // bus conditions and the stop task override any busy state but ST_STOPPING
    if (state_q != ST_IDLE && state_q != ST_STOPPING) begin
      if (i_stop_task || (stop_seen && active_q)) begin
        state_d = ST_STOPPING;
        scl_oe_d = 1'b0;
        sda_oe_d = 1'b0;
      end else if (stop_seen) begin
        state_d = ST_IDLE;
        scl_oe_d = 1'b0;
        sda_oe_d = 1'b0;
      end else if (start_seen) begin
        state_d = ST_ADDR;
        bitcnt_d = BIT_CNT_RST;
        fetch_d = 1'b0;
        scl_oe_d = 1'b0;
        sda_oe_d = 1'b0;
      end
    end
    // disabling releases the bus; settings are inputs, kept as given
    if (!i_enable) begin
      state_d = ST_IDLE;
      active_d = 1'b0;
      scl_oe_d = 1'b0;
      sda_oe_d = 1'b0;
    end
    // a prepare task wins over a same-cycle unprepare
    if (i_prepare_transmit_task) begin
      tx_prep_d = 1'b1;
    end
    if (i_prepare_receive_task) begin
      rx_prep_d = 1'b1;
    end
    sleep_d = i_enable && state_d == ST_IDLE;
  end

  ////////////////////////////////////////////////////////////////////////
  // state registers; everything freezes while i_clk_en is low
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_q <= ST_IDLE;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      shift_q <= BYTE_RST;
      bitcnt_q <= BIT_CNT_RST;
      rw_q <= 1'b0;
      active_q <= 1'b0;
      fetch_q <= 1'b0;
      tx_prep_q <= 1'b0;
      rx_prep_q <= 1'b0;
      o_scl_oe <= 1'b0;
      o_sda_oe <= 1'b0;
      o_scl_out <= 1'b0;
      o_sda_out <= 1'b0;
      ptr_q <= PTR_RST;
      max_q <= CNT_RST;
      cnt_q <= CNT_RST;
      o_tx_amount <= CNT_RST;
      o_rx_amount <= CNT_RST;
      o_mem_req <= 1'b0;
      o_mem_we <= 1'b0;
      o_mem_addr <= PTR_RST;
      o_mem_wdata <= BYTE_RST;
      o_receive_begun_event <= 1'b0;
      o_transmit_begun_event <= 1'b0;
      o_stopped_event <= 1'b0;
      o_error_event <= 1'b0;
      o_read_event <= 1'b0;
      o_write_event <= 1'b0;
      o_sleep <= 1'b0;
    end else if (i_clk_en) begin
      state_q <= state_d;
      scl_p_q <= scl_p_d;
      sda_p_q <= sda_p_d;
      shift_q <= shift_d;
      bitcnt_q <= bitcnt_d;
      rw_q <= rw_d;
      active_q <= active_d;
      fetch_q <= fetch_d;
      tx_prep_q <= tx_prep_d;
      rx_prep_q <= rx_prep_d;
      o_scl_oe <= scl_oe_d;
      o_sda_oe <= sda_oe_d;
      o_scl_out <= 1'b0;
      o_sda_out <= 1'b0;
      ptr_q <= ptr_d;
      max_q <= max_d;
      cnt_q <= cnt_d;
      o_tx_amount <= tx_amt_d;
      o_rx_amount <= rx_amt_d;
      o_mem_req <= mem_req_d;
      o_mem_we <= mem_we_d;
      o_mem_addr <= mem_addr_d;
      o_mem_wdata <= mem_wdata_d;
      o_receive_begun_event <= rxb_d;
      o_transmit_begun_event <= txb_d;
      o_stopped_event <= stp_d;
      o_error_event <= err_d;
      o_read_event <= rd_d;
      o_write_event <= wr_d;
      o_sleep <= sleep_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks on the control behaviour
  property p_tx_prep_set;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    i_clk_en && i_prepare_transmit_task |=> tx_prep_q;
  endproperty
  a_tx_prep_set: assert property (p_tx_prep_set)
    else $error("transmit prepare task did not set flag");

  property p_rx_prep_set;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    i_clk_en && i_prepare_receive_task |=> rx_prep_q;
  endproperty
  a_rx_prep_set: assert property (p_rx_prep_set)
    else $error("receive prepare task did not set flag");

  property p_tx_unprep;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    o_transmit_begun_event && !$past(i_prepare_transmit_task)
      |-> !tx_prep_q && state_q == ST_TX_FETCH;
  endproperty
  a_tx_unprep: assert property (p_tx_unprep)
    else $error("transmit start left prepared flag set");

  property p_rx_unprep;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    o_receive_begun_event && !$past(i_prepare_receive_task)
      |-> !rx_prep_q && state_q == ST_RX_BITS;
  endproperty
  a_rx_unprep: assert property (p_rx_unprep)
    else $error("receive start left prepared flag set");

  property p_stop_cond;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    i_clk_en && i_enable && stop_seen && active_q &&
      state_q != ST_IDLE && state_q != ST_STOPPING
      |=> state_q == ST_STOPPING;
  endproperty
  a_stop_cond: assert property (p_stop_cond)
    else $error("stop condition did not end the transaction");

  property p_stop_task;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    i_clk_en && i_enable && i_stop_task && state_q != ST_IDLE &&
      state_q != ST_STOPPING
      |=> state_q == ST_STOPPING && !o_scl_oe && !o_sda_oe;
  endproperty
  a_stop_task: assert property (p_stop_task)
    else $error("stop task did not end activity");

  property p_stopped_safe;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    o_stopped_event |-> !o_mem_req && !active_q && state_q == ST_IDLE;
  endproperty
  a_stopped_safe: assert property (p_stopped_safe)
    else $error("stopped raised with memory access pending");

  property p_event_pulse;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    i_clk_en && (o_stopped_event || o_transmit_begun_event)
      |=> !o_stopped_event && !o_transmit_begun_event;
  endproperty
  a_event_pulse: assert property (p_event_pulse)
    else $error("event output longer than one cycle");

  property p_wait_stretch;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    state_q == ST_WAIT_PREP |-> o_scl_oe && !o_sda_oe;
  endproperty
  a_wait_stretch: assert property (p_wait_stretch)
    else $error("clock not stretched while awaiting prepare");

  property p_over_read;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    i_clk_en && i_enable && state_q == ST_TX_FETCH && cnt_q >= max_q &&
      !i_stop_task && !stop_seen && !start_seen
      |=> o_error_event && shift_q == $past(i_over_read_fill_byte);
  endproperty
  a_over_read: assert property (p_over_read)
    else $error("over-read did not send fill byte");

  property p_sleep;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    o_sleep |-> state_q == ST_IDLE && !o_scl_oe && !o_sda_oe;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("sleep shown while not idle");
endmodule

// File: twsd_bus_master.sv
/*
  Bus master model driving the serial clock and data lines.
  Assumes pulled-up wires resolved by the bench from all enables.
*/
`timescale 1ns/1ps
module twsd_bus_master (
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_scl_oe,
  output logic o_sda_oe
);
  //////////////////////////////////////////////////////////////////////
  // lines released at start; lone master, so no arbitration
  initial begin
    o_scl_oe = 1'h0;
    o_sda_oe = 1'h0;
  end

  // release clock, wait out a stretch; bounded so a hang cannot stall
  task automatic rise();
    int n;
    o_scl_oe = 1'h0;
    n = 0;
    while (i_scl !== 1'h1 && n < 4000) begin
      #10;
      n++;
    end
    #40;
  endtask

  // data changes mid-low, read late in the high phase for margin
  task automatic bit_io(input logic b, output logic s);
    o_scl_oe = 1'h1;
    #20;
    o_sda_oe = ~b;
    #20;
    rise();
    s = i_sda;
  endtask

  // fresh start from idle, otherwise a restart mid-transfer
  task automatic start(input logic fresh);
    if (!fresh) begin
      o_scl_oe = 1'h1;
      #20;
      o_sda_oe = 1'h0;
      #20;
      rise();
    end
    o_sda_oe = 1'h1;
    #40;
  endtask

  // stop: data rises while clock high
  task automatic stop();
    o_scl_oe = 1'h1;
    #20;
    o_sda_oe = 1'h1;
    #20;
    rise();
    o_sda_oe = 1'h0;
    #40;
  endtask

  // byte msb first, then the acknowledge bit
  task automatic xfer(input logic [7:0] d, input logic ma,
                      output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(ma, a);
  endtask
endmodule

// File: twsd_serial_slave_unit_tb.sv
/*
  Self-checking bench for the serial slave unit: a table of plain
  transfers, then stretch, stop task, restart and limit cases.
  Assumes the bus master model; memory here answers in three cycles.
*/
`timescale 1ns/1ps
module twsd_serial_slave_unit_tb;
  import twsd_pkg::*;
  typedef struct packed {
    logic [6:0] adr;
    logic rd;
    logic [3:0] n;
    logic ack;
  } twsd_row_t;
  localparam twsd_row_t ROWS [4] = '{
    '{7'h2A, 1'h0, 4'h2, 1'h1}, '{7'h55, 1'h1, 4'h3, 1'h1},
    '{7'h55, 1'h0, 4'h1, 1'h1}, '{7'h33, 1'h0, 4'h1, 1'h0}};
  logic clk, rst_n, en, prep_tx, prep_rx, stop_t, mem_ack, a0_en, a1_en;
  logic [BYTE_W-1:0] mem_rdata, fill, mem_wdata;
  logic [PTR_W-1:0] tx_ptr, rx_ptr, mem_addr;
  logic [CNT_W-1:0] tx_max, rx_max, tx_amt, rx_amt;
  logic [ADDR7_W-1:0] adr0, adr1;
  logic m_scl_oe, m_sda_oe, scl_oe, sda_oe, mem_req, mem_we, sleep;
  logic scl_o, sda_o, ce;
  wire scl, sda;
  wire [5:0] evs;
  logic [7:0] mem [256];
  logic [7:0] got [4];
  logic sack [4];
  int ev [6];
  int failures, cmp_count, mw;

  //////////////////////////////////////////////////////////////////////
  // pulled-up wires; the slave puts its out value on while enabled
  assign scl = ~m_scl_oe & (scl_oe ? scl_o : 1'h1);
  assign sda = ~m_sda_oe & (sda_oe ? sda_o : 1'h1);

  twsd_bus_master i_twsd_bus_master (
    .i_scl(scl),
    .i_sda(sda),
    .o_scl_oe(m_scl_oe),
    .o_sda_oe(m_sda_oe)
  );

  twsd_serial_slave_unit i_twsd_serial_slave_unit (
    .i_sys_clk(clk),
    .i_reset_n(rst_n),
    .i_clk_en(ce),
    .i_enable(en),
    .i_addr0(adr0),
    .i_addr0_en(a0_en),
    .i_addr1(adr1),
    .i_addr1_en(a1_en),
    .i_tx_ptr(tx_ptr),
    .i_tx_maxcnt(tx_max),
    .i_rx_ptr(rx_ptr),
    .i_rx_maxcnt(rx_max),
    .i_over_read_fill_byte(fill),
    .i_prepare_transmit_task(prep_tx),
    .i_prepare_receive_task(prep_rx),
    .i_stop_task(stop_t),
    .i_scl(scl),
    .i_sda(sda),
    .o_scl_out(scl_o),
    .o_scl_oe(scl_oe),
    .o_sda_out(sda_o),
    .o_sda_oe(sda_oe),
    .o_mem_req(mem_req),
    .o_mem_we(mem_we),
    .o_mem_addr(mem_addr),
    .o_mem_wdata(mem_wdata),
    .i_mem_ack(mem_ack),
    .i_mem_rdata(mem_rdata),
    .o_receive_begun_event(evs[0]),
    .o_transmit_begun_event(evs[1]),
    .o_stopped_event(evs[2]),
    .o_error_event(evs[3]),
    .o_read_event(evs[4]),
    .o_write_event(evs[5]),
    .o_tx_amount(tx_amt),
    .o_rx_amount(rx_amt),
    .o_sleep(sleep)
  );

  // 100 MHz system clock
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  // count pulses on the falling edge, clear of the launching edge
  always @(negedge clk) begin
    for (int k = 0; k < 6; k++) begin
      if (evs[k] === 1'h1) ev[k]++;
    end
    if (evs[2] === 1'h1) chk(mem_req !== 1'h1, "stop with memory busy");
  end

  // memory: three-cycle answer, junk data outside the ack cycle
  always @(negedge clk) begin
    if (mem_ack) begin
      mem_ack = 1'h0;
      mw = 0;
    end else if (mem_req === 1'h1) begin
      mw++;
      if (mw == 3) begin
        mem_ack = 1'h1;
        mem_rdata = mem[mem_addr[7:0]];
        if (mem_we) mem[mem_addr[7:0]] = mem_wdata;
      end
    end else begin
      mem_rdata = ~mem_rdata;
    end
  end

  task automatic chk(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1'h1) begin
      failures++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask

  // one-cycle task pulse: 0 transmit, 1 receive, 2 stop
  task automatic trig(input int k);
    @(negedge clk);
    {prep_tx, prep_rx, stop_t} = 3'h4 >> k;
    @(negedge clk);
    {prep_tx, prep_rx, stop_t} = 3'h0;
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic fin();
    i_twsd_bus_master.stop();
    idle(30);
  endtask

  // addressed transfer without stop; master nacks its last read
  task automatic txn(input logic fr, input logic [6:0] a, input logic rd,
                     input int n, output logic ak);
    logic [7:0] q;
    foreach (ev[k]) ev[k] = 0;
    i_twsd_bus_master.start(fr);
    i_twsd_bus_master.xfer({a, rd}, 1'h1, q, ak);
    for (int i = 0; i < n && ak === 1'h0; i++) begin
      i_twsd_bus_master.xfer(rd ? 8'hFF : 8'hA0 + 8'(i),
                             rd ? i == n - 1 : 1'h1, got[i], sack[i]);
    end
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // plan takes about 3000 cycles; cut well beyond that
  initial begin
    #600000;
    failures++;
    results();
  end

  // main sequence: configure while disabled, table, then hard cases
  initial begin
    logic ak;
    twsd_row_t r;
    {rst_n, en, prep_tx, prep_rx, stop_t, mem_ack} = 6'h00;
    ce = 1'h1;
    {a0_en, a1_en} = 2'h3;
    {adr0, adr1, fill, mem_rdata} = {7'h2A, 7'h55, 8'hEE, 8'h00};
    {tx_ptr, rx_ptr} = {32'h00000010, 32'h00000080};
    {tx_max, rx_max} = {13'h0008, 13'h0008};
    for (int i = 0; i < 256; i++) mem[i] = 8'h30 + 8'(i);
    repeat (20) @(posedge clk);
    chk({scl_oe, sda_oe, mem_req, sleep, evs} === 10'h000, "reset");
    idle(1);
    rst_n = 1'h1;
    ce = 1'h0;
    idle(3);
    en = 1'h1;
    idle(5);
    chk(sleep === 1'h0, "frozen while clock enable low");
    ce = 1'h1;
    idle(5);
    chk(sleep === 1'h1, "sleep when idle");
    foreach (ROWS[j]) begin
      r = ROWS[j];
      if (r.ack) trig(r.rd ? 0 : 1);
      txn(1'h1, r.adr, r.rd, r.n, ak);
      fin();
      chk(ak === ~r.ack, "address acknowledge");
      chk(ev[2] == r.ack && ev[4] == (r.ack & r.rd) && ev[3] == 0 &&
          ev[0] == (r.ack & ~r.rd), "events");
      chk(ev[5] == (r.ack & ~r.rd) && ev[1] == (r.ack & r.rd), "events");
      for (int i = 0; i < r.n && r.ack; i++) begin
        if (r.rd) chk(got[i] === 8'h40 + 8'(i), "read data");
        else chk(mem[8'h80 + 8'(i)] === 8'hA0 + 8'(i), "stored");
      end
      if (r.ack) chk((r.rd ? tx_amt : rx_amt) === 13'(r.n), "amount");
    end
    // transmit flag used up: read must hold the clock until prepared
    fork
      txn(1'h1, 7'h2A, 1'h1, 1, ak);
      begin
        idle(300);
        chk(scl_oe === 1'h1 && scl_o === 1'h0 && ev[1] == 0 &&
            sleep === 1'h0, "stretch");
        trig(0);
      end
    join
    fin();
    chk(ev[1] == 1 && got[0] === 8'h40, "read after prepare");
    // receive flag used up: stop task ends the stretched write
    fork
      txn(1'h1, 7'h55, 1'h0, 1, ak);
      begin
        idle(300);
        chk(scl_oe === 1'h1 && ev[0] == 0, "write stretch");
        trig(2);
        idle(20);
        chk(ev[2] == 1 && scl_oe === 1'h0, "stop task");
      end
    join
    fin();
    chk(ev[2] == 1 && ev[0] == 0, "single stopped");
    // write then restart into a read: one stopped at the end only
    trig(1);
    trig(0);
    txn(1'h1, 7'h2A, 1'h0, 1, ak);
    txn(1'h0, 7'h2A, 1'h1, 1, ak);
    fin();
    chk(ev[2] == 1 && ev[1] == 1 && got[0] === 8'h40, "restart");
    // limits changed only while disabled
    en = 1'h0;
    idle(3);
    chk(sleep === 1'h0, "no sleep when disabled");
    {tx_max, rx_max} = {13'h0002, 13'h0002};
    en = 1'h1;
    idle(3);
    trig(0);
    txn(1'h1, 7'h55, 1'h1, 3, ak);
    fin();
    chk(got[1] === 8'h41 && got[2] === fill && ev[3] == 1, "over-read");
    chk(tx_amt === 13'h0003, "over-read amount");
    trig(1);
    txn(1'h1, 7'h2A, 1'h0, 3, ak);
    fin();
    chk(sack[1] === 1'h0 && sack[2] === 1'h1 && ev[3] == 1, "overflow");
    chk(mem[8'h82] === 8'hB2, "discarded byte");
    results();
  end
endmodule
